/* File: rgb_host_model.sv */
// Host video source: syncs, porches and 480 dots a line, enabled on active lines only.
// Assumes go_in rises once for each frame.
`timescale 1ns/1ns
module rgb_host_model #(
  parameter int LINES = 2,
  parameter int PORCH = 2
) (
  input wire logic go_in,
  input wire logic [23:0] pixel_data_in,
  output logic pixel_clock_out = 1'b0,
  output rgb_panel_pkg::video_in_t video_out = 27'h6000000,
  output logic done_out = 1'b0
);
  import rgb_panel_pkg::*;
  // Data moves after the falling edge; fresh bench bits every dot
  task automatic dots(input int n, input logic hs, input logic de);
    repeat (n)
    begin
      video_out.hsync_n = hs;
      video_out.data_en = de;
      video_out.pixel_bus = pixel_data_in;
      #24 pixel_clock_out = 1'b1;
      #24 pixel_clock_out = 1'b0;
    end
  endtask
  task automatic line(input logic de);
    dots(1, 1'b0, 1'b0);
    dots(PORCH, 1'b1, 1'b0);
    dots(480, 1'b1, de);
    dots(PORCH, 1'b1, 1'b0);
  endtask
  always @(posedge go_in)
  begin
    video_out.vsync_n = 1'b0;
    line(1'b0);
    video_out.vsync_n = 1'b1;
    line(1'b0);
    repeat (LINES) line(1'b1);
    line(1'b0);
    done_out = 1'b1;
  end
endmodule

/* File: rgb_panel_consts.svh */
// Timing constants for the RGB panel input and reset block.
// Assumes a 250 MHz core clock; times are converted to cycles here.
// Contract
// - Reject under 5 us, reset over 9 us
// - Reload settings from store after reset release
// - Settle within 5 ms asleep, 120 ms awake
// - Blank display while resetting, then defaults
// - Filter short high spikes inside reset pulse
`ifndef RGB_PANEL_CONSTS_SVH
`define RGB_PANEL_CONSTS_SVH
`define CLK_PERIOD_NS 4
`define RESET_REJECT_US 5
`define RESET_ACCEPT_US 9
`define SPIKE_REJECT_US 5
`define SETTLE_SLEEP_MS 5
`define SETTLE_AWAKE_MS 120
`define RESET_REJECT_CYC ((`RESET_REJECT_US * 1000) / `CLK_PERIOD_NS)
`define RESET_ACCEPT_CYC ((`RESET_ACCEPT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPIKE_REJECT_CYC ((`SPIKE_REJECT_US * 1000) / `CLK_PERIOD_NS)
`define SETTLE_SLEEP_CYC ((`SETTLE_SLEEP_MS * 1000000) / `CLK_PERIOD_NS)
`define SETTLE_AWAKE_CYC ((`SETTLE_AWAKE_MS * 1000000) / `CLK_PERIOD_NS)
`define LINE_ACTIVE_LEN 480
`define SETTINGS_WORDS 4
`endif

/* File: rgb_panel_pkg.sv */
// Types for the RGB panel input and reset block.
// Assumes the constants header is included by users.
package rgb_panel_pkg;
  typedef enum logic [1:0] {MODE_16, MODE_18, MODE_24} pixel_mode_t;
  typedef struct packed {
    logic hsync_n;
    logic vsync_n;
    logic data_en;
    logic [23:0] pixel_bus;
  } video_in_t;
  typedef struct packed {
    logic [23:0] rgb;
    logic valid;
    logic line_start;
    logic frame_start;
  } pixel_out_t;
endpackage

/* File: rgb_panel_timing_and_reset.sv */
// Device side RGB video capture and hardware reset qualifier.
// Assumes all pins are asynchronous to clk_in; pixel clock sampled as data.
`timescale 1ns/1ns
`include "rgb_panel_consts.svh"
module rgb_panel_timing_and_reset #(
  parameter int SETTLE_SLEEP_CYC = `SETTLE_SLEEP_CYC,
  parameter int SETTLE_AWAKE_CYC = `SETTLE_AWAKE_CYC,
  parameter int REJECT_CYC = `RESET_REJECT_CYC,
  parameter int ACCEPT_CYC = `RESET_ACCEPT_CYC,
  parameter int SPIKE_CYC = `SPIKE_REJECT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_n_pin_in,
  input wire logic pixel_clock_in,
  input wire rgb_panel_pkg::video_in_t video_in,
  input wire rgb_panel_pkg::pixel_mode_t mode_in,
  input wire logic sleep_in,
  input wire logic [31:0] store_word_in,
  output logic [1:0] store_addr_out,
  output logic store_rd_out,
  output logic [31:0] settings_out [`SETTINGS_WORDS],
  output logic blank_out,
  output logic busy_out,
  output logic panel_reset_out,
  output rgb_panel_pkg::pixel_out_t pixel_out
);
  import rgb_panel_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_LOW, ST_RESET, ST_SETTLE} rst_state_t;

  localparam int CW = 26;

  logic [1:0] rst_sync_reg;
  logic [2:0] pclk_sync_reg;
  video_in_t vid_s1_reg;
  video_in_t vid_s2_reg;
  rst_state_t state_reg;
  logic [CW-1:0] low_cnt_reg;
  logic [CW-1:0] high_cnt_reg;
  logic [CW-1:0] settle_cnt_reg;
  logic [CW-1:0] settle_lim_reg;
  logic [2:0] load_idx_reg;
  logic load_pend_reg;
  logic [1:0] load_slot_reg;
  logic hs_prev_reg;
  logic vs_prev_reg;
  logic [9:0] pix_cnt_reg;

  logic pin_low;
  logic pclk_rise;

  assign pin_low = !rst_sync_reg[1];
  assign pclk_rise = pclk_sync_reg[1] && !pclk_sync_reg[2];

  function automatic logic [23:0] pack_pixel(input pixel_mode_t m, input logic [23:0] d);
    logic [23:0] r;
    r = d;
    unique case (m)
      MODE_16: r = {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
      MODE_18: r = {d[17:12], d[17:16], d[11:6], d[11:10], d[5:0], d[5:4]};
      MODE_24: r = d;
      // Unused code passes the bus through unchanged
      default: r = d;
    endcase
    return r;
  endfunction

  // Two stages before any logic reads a pin
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync_reg <= 2'h3;
      pclk_sync_reg <= 3'h0;
      vid_s1_reg <= '0;
      vid_s2_reg <= '0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], reset_n_pin_in};
      pclk_sync_reg <= {pclk_sync_reg[1:0], pixel_clock_in};
      vid_s1_reg <= video_in;
      vid_s2_reg <= vid_s1_reg;
    end
  end

  // Reset pulse qualifier and settle sequencer
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= ST_SETTLE;
      low_cnt_reg <= '0;
      high_cnt_reg <= '0;
      settle_cnt_reg <= '0;
      settle_lim_reg <= CW'(SETTLE_SLEEP_CYC);
    end
    else
    begin
      unique case (state_reg)
        ST_RUN:
        begin
          low_cnt_reg <= '0;
          high_cnt_reg <= '0;
          if (pin_low)
            state_reg <= ST_LOW;
        end
        ST_LOW:
        begin
          if (pin_low)
          begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
            if (low_cnt_reg >= CW'(ACCEPT_CYC))
              state_reg <= ST_RESET;
          end
          else if (low_cnt_reg < CW'(REJECT_CYC))
            state_reg <= ST_RUN;
          else
            state_reg <= ST_RESET;
        end
        ST_RESET:
        begin
          // Settle budget chosen by the power state on the last reset cycle
          settle_lim_reg <= sleep_in ? CW'(SETTLE_SLEEP_CYC) : CW'(SETTLE_AWAKE_CYC);
          settle_cnt_reg <= '0;
          if (pin_low)
            high_cnt_reg <= '0;
          else if (high_cnt_reg >= CW'(SPIKE_CYC))
            state_reg <= ST_SETTLE;
          else
            high_cnt_reg <= high_cnt_reg + 1'b1;
        end
        ST_SETTLE:
        begin
          if (pin_low)
          begin
            state_reg <= ST_LOW;
            low_cnt_reg <= '0;
          end
          else if (settle_cnt_reg >= settle_lim_reg - 1'b1)
            state_reg <= ST_RUN;
          else
            settle_cnt_reg <= settle_cnt_reg + 1'b1;
        end
      endcase
    end
  end

  // Settings reload; one word per cycle, far inside the settle budget
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      load_idx_reg <= '0;
      load_pend_reg <= 1'b0;
      load_slot_reg <= '0;
      store_addr_out <= '0;
      store_rd_out <= 1'b0;
      for (int i = 0; i < `SETTINGS_WORDS; i++)
        settings_out[i] <= '0;
    end
    else
    begin
      load_pend_reg <= store_rd_out;
      load_slot_reg <= store_addr_out;
      if (load_pend_reg)
        settings_out[load_slot_reg] <= store_word_in;
      if (state_reg != ST_SETTLE)
      begin
        load_idx_reg <= '0;
        store_rd_out <= 1'b0;
      end
      else if (load_idx_reg < 3'(`SETTINGS_WORDS))
      begin
        store_rd_out <= 1'b1;
        store_addr_out <= load_idx_reg[1:0];
        load_idx_reg <= load_idx_reg + 1'b1;
      end
      else
        store_rd_out <= 1'b0;
    end
  end

  // Blanking and status; blank holds through reset and settle, but drops while a pin low during settle is qualified
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      blank_out <= 1'b1;
      busy_out <= 1'b1;
      panel_reset_out <= 1'b1;
    end
    else
    begin
      blank_out <= (state_reg == ST_RESET) || (state_reg == ST_SETTLE);
      busy_out <= state_reg != ST_RUN;
      panel_reset_out <= state_reg == ST_RESET;
    end
  end

  // Pixel capture on sampled dot clock rising edges
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pixel_out <= '0;
      hs_prev_reg <= 1'b1;
      vs_prev_reg <= 1'b1;
      pix_cnt_reg <= '0;
    end
    else
    begin
      pixel_out.valid <= 1'b0;
      pixel_out.line_start <= 1'b0;
      pixel_out.frame_start <= 1'b0;
      if (pclk_rise && state_reg == ST_RUN)
      begin
        hs_prev_reg <= vid_s2_reg.hsync_n;
        vs_prev_reg <= vid_s2_reg.vsync_n;
        if (hs_prev_reg && !vid_s2_reg.hsync_n)
        begin
          pixel_out.line_start <= 1'b1;
          pix_cnt_reg <= '0;
        end
        if (vs_prev_reg && !vid_s2_reg.vsync_n)
          pixel_out.frame_start <= 1'b1;
        // Extra enabled pixels past the line length are dropped
        if (vid_s2_reg.data_en && pix_cnt_reg < 10'(`LINE_ACTIVE_LEN))
        begin
          pixel_out.valid <= 1'b1;
          pixel_out.rgb <= pack_pixel(mode_in, vid_s2_reg.pixel_bus);
          pix_cnt_reg <= pix_cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule

/* File: rgb_panel_timing_and_reset_asserts.sv */
// Checker for reset qualification, blanking, settle and reload.
// Assumes shortened counts are handed down through the bind.
`timescale 1ns/1ns
module rgb_panel_timing_and_reset_asserts #(
  parameter int SETTLE_AWAKE_CYC = 200
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_n_pin_in,
  input wire logic store_rd_out,
  input wire logic [1:0] store_addr_out,
  input wire logic blank_out,
  input wire logic busy_out,
  input wire logic panel_reset_out
);
  localparam int SETTLE_MAX = SETTLE_AWAKE_CYC + 8;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_blanks:
    assert property (panel_reset_out |-> blank_out && busy_out) else $error("no blank in reset");
  a_short_ignored:
    assert property (!busy_out && $fell(reset_n_pin_in) ##1 !reset_n_pin_in[*3] ##1 reset_n_pin_in
      |-> !panel_reset_out[*8]) else $error("short pulse reset");
  a_spike_held:
    assert property (panel_reset_out && $rose(reset_n_pin_in) ##1 reset_n_pin_in[*3] ##1 !reset_n_pin_in
      |-> panel_reset_out[*8]) else $error("spike ended reset");
  a_store_reload:
    assert property ($fell(panel_reset_out) |-> (store_rd_out && store_addr_out == 2'h0)
      ##3 (store_rd_out && store_addr_out == 2'h3) ##1 !store_rd_out) else $error("no reload");
  a_settle_bound:
    assert property ($fell(panel_reset_out) |-> ##[1:SETTLE_MAX] !busy_out) else $error("settle too long");
  cover property ($rose(panel_reset_out));
  cover property ($fell(busy_out));
  cover property (store_rd_out);
endmodule
bind rgb_panel_timing_and_reset rgb_panel_timing_and_reset_asserts #(.SETTLE_AWAKE_CYC(SETTLE_AWAKE_CYC))
  i_asserts (.clk_in, .rst_n_in, .reset_n_pin_in, .store_rd_out, .store_addr_out, .blank_out, .busy_out,
  .panel_reset_out);

/* File: rgb_panel_timing_and_reset_tb.sv */
// Bench: power-on load, short and long pin pulses with spikes, one frame in all modes.
// Assumes the host model and the checker are compiled with it.
`timescale 1ns/1ns
module rgb_panel_timing_and_reset_tb;
  import rgb_panel_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, pin = 1'b1, sleep = 1'b1, go = 1'b0, seen;
  logic done, rd, pclk, blank, busy, prst;
  logic [1:0] addr;
  logic [31:0] word = 32'h0, rnd = 32'h1A, pdata = 32'h0;
  logic [31:0] mem [4];
  logic [31:0] settings [4];
  video_in_t video;
  pixel_out_t pout;
  int failures = 0, checks = 0, nv = 0;
  int nl = 0, nf = 0;
  pixel_mode_t mode = MODE_24;
  logic [23:0] last = 24'h0;
  logic rd_q = 1'b0;
  logic [1:0] addr_q = 2'h0;
  rgb_host_model #(.LINES(3)) i_rgb_host_model (.go_in(go), .pixel_data_in(pdata[23:0]), .pixel_clock_out(pclk),
    .video_out(video), .done_out(done));
  rgb_panel_timing_and_reset #(.SETTLE_SLEEP_CYC(50), .SETTLE_AWAKE_CYC(200), .REJECT_CYC(10), .ACCEPT_CYC(18),
    .SPIKE_CYC(10)) i_rgb_panel_timing_and_reset (.clk_in, .rst_n_in, .reset_n_pin_in(pin), .pixel_clock_in(pclk),
    .video_in(video), .mode_in(mode), .sleep_in(sleep), .store_word_in(word), .store_addr_out(addr),
    .store_rd_out(rd), .settings_out(settings), .blank_out(blank), .busy_out(busy), .panel_reset_out(prst),
    .pixel_out(pout));
  initial
    forever #2 clk_in = ~clk_in;
  // Store answers in the cycle after the read strobe is taken
  always @(negedge clk_in)
  begin
    if (rd_q)
      word = mem[addr_q];
    rd_q = rd;
    addr_q = addr;
  end
  // Word the host shows at each dot clock rise
  always @(posedge pclk)
    last = video.pixel_bus;
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  function automatic int slen(input logic s);
    return s ? 50 : 200;
  endfunction
  // Narrow modes widen each channel by repeating its top bits
  function automatic logic [23:0] exp_rgb(input pixel_mode_t m, input logic [23:0] d);
    logic [7:0] r, g, b;
    r = d[23:16];
    g = d[15:8];
    b = d[7:0];
    if (m == MODE_16)
    begin
      r = {d[15:11], d[15:13]};
      g = {d[10:5], d[10:9]};
      b = {d[4:0], d[4:2]};
    end
    else if (m == MODE_18)
    begin
      r = {d[17:12], d[17:16]};
      g = {d[11:6], d[11:10]};
      b = {d[5:0], d[5:4]};
    end
    return {r, g, b};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
      $display("FAIL %0t got %0h exp %0h", $time, got, exp);
    failures += (got !== exp);
  endtask
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(negedge clk_in);
      seen |= prst;
      nv += pout.valid;
      nl += pout.line_start;
      nf += pout.frame_start;
      pdata = xs();
      if (pout.valid)
        chk(pout.rgb, exp_rgb(mode, last));
      // New mode only between lines, never inside active pixels
      if (pout.line_start)
        mode = pixel_mode_t'(nl % 3);
    end
  endtask
  task automatic settle(input logic s);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 999)
    begin
      cyc(1);
      k += !prst;
    end
    chk(k >= slen(s) - 2 && k <= slen(s) + 12, 1);
    foreach (mem[i]) chk(settings[i], mem[i]);
    chk(blank, 1'b0);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #300000;
    failures++;
    end_sim();
  end
  initial
  begin
    foreach (mem[i]) mem[i] = xs();
    cyc(5);
    rst_n_in = 1'b1;
    settle(1'b1);
    for (int i = 0; i < 3; i++)
    begin
      seen = 1'b0;
      pin = 1'b0;
      cyc(i == 0 ? 4 : i == 1 ? 9 : xs() % 9 + 1);
      pin = 1'b1;
      cyc(30);
      chk({seen, busy}, 2'b00);
    end
    for (int i = 0; i < 2; i++)
    begin
      sleep = i[0];
      foreach (mem[j]) mem[j] = xs();
      pin = 1'b0;
      cyc(i ? 14 : 30);
      pin = 1'b1;
      cyc(4);
      pin = 1'b0;
      cyc(8);
      chk({prst, blank}, 2'b11);
      pin = 1'b1;
      settle(i[0]);
    end
    // Frame only once busy has dropped
    nv = 0;
    nl = 0;
    nf = 0;
    go = 1'b1;
    cyc(1);
    while (done !== 1'b1)
      cyc(1);
    cyc(20);
    chk(nv, 1440);
    chk(nl, 6);
    chk(nf, 1);
    end_sim();
  end
endmodule
